//--- hw/cts_change_detect.v
// Purpose: Samples the clear-to-send input and keeps its change flag.
// Assumes: clear_to_send_in_n is synchronous to pclk.
// Notes:   A change in the cycle of the read-clear keeps the flag set.
`timescale 1ns/10ps
`default_nettype none
`include "uart_modem_irq_map.vh"

module cts_change_detect (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Modem line, active low
  input wire clear_to_send_in_n,
  // Read of the modem status register, one-cycle pulse
  input wire read_clear,
  // Status
  output reg cts_level,
  output reg clear_to_send_changed
);

  reg primed;
  wire changed_now;

  // No change is reported before the first sample after reset
  assign changed_now = primed & (cts_level != ~clear_to_send_in_n);

  // Line sample, shown as the complement of the active-low pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cts_level <= `RST_CTS_LEVEL;
      primed <= 1'b0;
    end
    else
    begin
      cts_level <= ~clear_to_send_in_n;
      primed <= 1'b1;
    end
  end

  // Sticky change flag; the set beats the read-clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clear_to_send_changed <= `RST_CTS_CHANGED;
    else if (changed_now)
      clear_to_send_changed <= 1'b1;
    else if (read_clear)
      clear_to_send_changed <= 1'b0;
  end

endmodule

`default_nettype wire

//--- hw/uart_modem_status_irq_mask.v
// Purpose: APB slave for the UART modem status and interrupt masking.
// Assumes: All event inputs are one-cycle pulses synchronous to pclk.
// Notes:   Every access completes with one wait-free access cycle.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "uart_modem_irq_map.vh"

module uart_modem_status_irq_mask (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Modem line, active low
  input wire clear_to_send_in_n,
  // Interrupt source events from the rest of the UART
  input wire rx_avail_event,
  input wire tx_empty_event,
  input wire line_status_event,
  input wire char_timeout_event,
  input wire busy_event,
  input wire autobaud_done_event,
  input wire autobaud_timeout_event,
  // Interrupt request, level
  output reg irq
);

  // Register map, one aligned word each:
  //   0x1c modem status: bit 4 line level, bit 0 change flag
  //   0x20 enable: ones written unmask sources, reads zero
  //   0x24 disable: ones written mask sources, reads zero
  //   0x28 mask view: current mask bits
  //   0x2c raw flags: sticky, independent of the masks
  //   0x30 status: raw and mask; ones written clear raw flags
  // Source bits: 7 autobaud timeout, 6 autobaud done, 5 busy,
  //   4 char timeout, 3 modem change, 2 line status,
  //   1 transmit empty, 0 receive data available
  //
  // Bus timing: setup at edge N, ready and read data at edge N+1,
  //   a write lands at the edge that samples ready, i.e. N+2.
  //   The change flag clears at edge N+1 with the read data, so a change that
  //   arrives later in the same access is kept for the next read.
  //
  // The modem source has no raw flop of its own: it is the change
  //   flag itself, so writing its status bit does nothing and only
  //   a status read can clear it.
  //
  // Event inputs are pulses; a source held high sets its flag again
  //   on every edge, so a clear written meanwhile does not stick.
  localparam NS = `NUM_SOURCES;

  // Word match; byte lanes below bit 2 are ignored
  function addr_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr[`ADDR_W-1:2] == ofs[`ADDR_W-1:2]);
    end
  endfunction

  // Sticky flag update; a set in the same cycle wins over a clear
  function [NS-1:0] set_over_clear;
    input [NS-1:0] cur;
    input [NS-1:0] set;
    input [NS-1:0] clr;
    begin
      set_over_clear = set | (cur & ~clr);
    end
  endfunction

  // Byte-lane gated low byte of the write data
  function [NS-1:0] low_byte;
    input [31:0] data;
    input [3:0] strb;
    begin
      low_byte = strb[0] ? data[NS-1:0] : {NS{1'b0}};
    end
  endfunction

  // State
  reg [NS-1:0] irq_mask_view;
  reg [NS-1:0] irq_raw_flags;
  wire cts_level;
  wire clear_to_send_changed;

  // Bus phase decode
  wire setup_phase;
  wire access_done;
  wire wr_done;
  wire rd_setup;

  // Address decode
  wire hit_status;
  wire hit_set;
  wire hit_clear;
  wire hit_view;
  wire hit_raw;
  wire hit_isc;
  wire mapped;

  // Write effects
  wire [NS-1:0] wr_bits;
  wire [NS-1:0] unmask_bits;
  wire [NS-1:0] mask_bits;
  wire [NS-1:0] flag_clear_bits;
  wire [NS-1:0] event_bits;
  wire [NS-1:0] next_irq_mask_view;
  wire [NS-1:0] next_irq_raw_flags;
  wire [NS-1:0] masked_status;
  wire [NS-1:0] raw_view;
  wire status_read;

  // Per-source requests of one enable write
  wire rx_avail_unmask;
  wire tx_empty_unmask;
  wire line_status_unmask;
  wire modem_change_unmask;
  wire char_timeout_unmask;
  wire busy_unmask;
  wire autobaud_done_unmask;
  wire autobaud_timeout_unmask;

  // Per-source requests of one disable write
  wire rx_avail_mask;
  wire tx_empty_mask;
  wire line_status_mask;
  wire modem_change_mask;
  wire char_timeout_mask;
  wire busy_mask;
  wire autobaud_done_mask;
  wire autobaud_timeout_mask;

  // Read data mux
  reg [31:0] next_prdata;

  // Setup cycle is where the read snapshot and error answer are formed
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite;
  assign rd_setup = setup_phase & ~pwrite;

  assign hit_status = addr_hit(paddr, `OFS_MODEM_LINE_STATUS);
  assign hit_set = addr_hit(paddr, `OFS_IRQ_MASK_SET);
  assign hit_clear = addr_hit(paddr, `OFS_IRQ_MASK_CLEAR);
  assign hit_view = addr_hit(paddr, `OFS_IRQ_MASK_VIEW);
  assign hit_raw = addr_hit(paddr, `OFS_IRQ_RAW_FLAGS);
  assign hit_isc = addr_hit(paddr, `OFS_IRQ_STATUS_CLEAR);
  assign mapped = hit_status | hit_set | hit_clear | hit_view | hit_raw | hit_isc;

  // Clear-on-read acts at the snapshot edge, so no change slips between
  // the value software sees and the clear
  assign status_read = rd_setup & hit_status;

  // Only ones written take effect; zeros leave other sources alone
  assign wr_bits = low_byte(pwdata, pstrb);

  // Enable-register bits, one per source; a zero written asks nothing
  assign rx_avail_unmask = wr_done & hit_set & wr_bits[`SRC_RX_AVAIL];
  assign tx_empty_unmask = wr_done & hit_set & wr_bits[`SRC_TX_EMPTY];
  assign line_status_unmask = wr_done & hit_set & wr_bits[`SRC_LINE_STATUS];
  assign modem_change_unmask = wr_done & hit_set & wr_bits[`SRC_MODEM_CHANGE];
  assign char_timeout_unmask = wr_done & hit_set & wr_bits[`SRC_CHAR_TIMEOUT];
  assign busy_unmask = wr_done & hit_set & wr_bits[`SRC_BUSY];
  assign autobaud_done_unmask = wr_done & hit_set & wr_bits[`SRC_AUTOBAUD_DONE];
  assign autobaud_timeout_unmask = wr_done & hit_set & wr_bits[`SRC_AUTOBAUD_TIMEOUT];

  // Disable-register bits in the very same layout
  assign rx_avail_mask = wr_done & hit_clear & wr_bits[`SRC_RX_AVAIL];
  assign tx_empty_mask = wr_done & hit_clear & wr_bits[`SRC_TX_EMPTY];
  assign line_status_mask = wr_done & hit_clear & wr_bits[`SRC_LINE_STATUS];
  assign modem_change_mask = wr_done & hit_clear & wr_bits[`SRC_MODEM_CHANGE];
  assign char_timeout_mask = wr_done & hit_clear & wr_bits[`SRC_CHAR_TIMEOUT];
  assign busy_mask = wr_done & hit_clear & wr_bits[`SRC_BUSY];
  assign autobaud_done_mask = wr_done & hit_clear & wr_bits[`SRC_AUTOBAUD_DONE];
  assign autobaud_timeout_mask = wr_done & hit_clear & wr_bits[`SRC_AUTOBAUD_TIMEOUT];

  // Gathered back into the common source order
  assign unmask_bits = {autobaud_timeout_unmask, autobaud_done_unmask, busy_unmask,
                        char_timeout_unmask, modem_change_unmask, line_status_unmask,
                        tx_empty_unmask, rx_avail_unmask};
  assign mask_bits = {autobaud_timeout_mask, autobaud_done_mask, busy_mask,
                      char_timeout_mask, modem_change_mask, line_status_mask,
                      tx_empty_mask, rx_avail_mask};
  assign flag_clear_bits = (wr_done & hit_isc) ? wr_bits : {NS{1'b0}};

  // Mask update; set and clear registers cannot be hit in one access
  assign next_irq_mask_view = (irq_mask_view | unmask_bits) & ~mask_bits;

  // Source events in the common bit layout
  assign event_bits[`SRC_RX_AVAIL] = rx_avail_event;
  assign event_bits[`SRC_TX_EMPTY] = tx_empty_event;
  assign event_bits[`SRC_LINE_STATUS] = line_status_event;
  assign event_bits[`SRC_MODEM_CHANGE] = 1'b0;
  assign event_bits[`SRC_CHAR_TIMEOUT] = char_timeout_event;
  assign event_bits[`SRC_BUSY] = busy_event;
  assign event_bits[`SRC_AUTOBAUD_DONE] = autobaud_done_event;
  assign event_bits[`SRC_AUTOBAUD_TIMEOUT] = autobaud_timeout_event;

  // Raw flags are sticky and independent of the masks
  assign next_irq_raw_flags = set_over_clear(irq_raw_flags, event_bits, flag_clear_bits);

  // Modem source is a level that tracks the change flag, not a latch
  assign raw_view = {irq_raw_flags[NS-1:`SRC_MODEM_CHANGE+1],
                     clear_to_send_changed,
                     irq_raw_flags[`SRC_MODEM_CHANGE-1:0]};

  // Masked sources read as zero
  assign masked_status = raw_view & irq_mask_view;

  // Clear-to-send sampling and change flag
  cts_change_detect u_cts (
    .pclk(pclk),
    .presetn(presetn),
    .clear_to_send_in_n(clear_to_send_in_n),
    .read_clear(status_read),
    .cts_level(cts_level),
    .clear_to_send_changed(clear_to_send_changed)
  );

  // Read data selection; write-only and reserved positions give zero
  always @*
  begin
    next_prdata = `RST_WORD;
    if (hit_status)
    begin
      next_prdata[`BIT_CTS_CHANGED] = clear_to_send_changed;
      next_prdata[`BIT_CTS_LEVEL] = cts_level;
    end
    else if (hit_set | hit_clear)
      next_prdata = `RST_WORD;
    else if (hit_view)
      next_prdata[NS-1:0] = irq_mask_view;
    else if (hit_raw)
      next_prdata[NS-1:0] = raw_view;
    else if (hit_isc)
      next_prdata[NS-1:0] = masked_status;
  end

  // APB answer: ready rises for the access cycle after every setup,
  // giving no wait state while keeping the outputs flopped.
  // Limitation: the error answer covers unmapped words only; writes
  // to read-only words are dropped quietly
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RST_WORD;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~mapped;
      if (rd_setup)
        prdata <= next_prdata;
      else if (setup_phase)
        prdata <= `RST_WORD;
    end
  end

  // Mask bits, all masked after reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_view <= `RST_MASK;
    else
      irq_mask_view <= next_irq_mask_view;
  end

  // Raw flags; transmit empty starts set because the holder is empty
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_raw_flags <= `RST_RAW;
    else
      irq_raw_flags <= next_irq_raw_flags;
  end

  // Interrupt line is one cycle behind the flags to stay flopped.
  // The clear-to-send level itself goes nowhere near transmit or
  // receive: it only reaches software through the status word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |masked_status;
  end

endmodule

`default_nettype wire

//--- shared/uart_modem_irq_map.vh
// Purpose: Register offsets, field positions and reset values of the
//          modem status and interrupt mask block.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only; include by bare name.
`ifndef UART_MODEM_IRQ_MAP_VH
`define UART_MODEM_IRQ_MAP_VH

// Address width of the APB slave
`define ADDR_W 12

// Register byte offsets
`define OFS_MODEM_LINE_STATUS 12'h01c
`define OFS_IRQ_MASK_SET 12'h020
`define OFS_IRQ_MASK_CLEAR 12'h024
`define OFS_IRQ_MASK_VIEW 12'h028
`define OFS_IRQ_RAW_FLAGS 12'h02c
`define OFS_IRQ_STATUS_CLEAR 12'h030

// Modem status fields
`define BIT_CTS_CHANGED 0
`define BIT_CTS_LEVEL 4

// Interrupt source positions, shared by every mask and flag register
`define SRC_RX_AVAIL 0
`define SRC_TX_EMPTY 1
`define SRC_LINE_STATUS 2
`define SRC_MODEM_CHANGE 3
`define SRC_CHAR_TIMEOUT 4
`define SRC_BUSY 5
`define SRC_AUTOBAUD_DONE 6
`define SRC_AUTOBAUD_TIMEOUT 7
`define NUM_SOURCES 8

// Reset values
`define RST_MASK 8'h00
`define RST_RAW 8'h02
`define RST_WORD 32'h00000000
`define RST_CTS_LEVEL 1'h0
`define RST_CTS_CHANGED 1'h0

`endif

//--- verification/cts_modem.sv
// Purpose: Modem partner that drives the clear-to-send line.
// Assumes: Line changes just after a pclk edge, synchronous to pclk.
// Notes:   Line idles deasserted (high) until the bench asks.
`timescale 1ns/10ps
`default_nettype none
module cts_modem (
  // Clock
  input wire logic pclk,
  // Bench request: 1 asserts the line
  input wire logic assert_req,
  // Modem line, active low
  output logic clear_to_send_in_n
);
  // Deasserted at time zero so no change is seen out of reset
  initial clear_to_send_in_n = 1'b1;
  // Registered so the line never moves on the sampling edge
  always @(posedge pclk)
    clear_to_send_in_n <= ~assert_req;
endmodule
`default_nettype wire

//--- verification/irq_mask_properties.sv
// Purpose: Port-level checks of the modem status and mask block.
// Assumes: One pclk domain, presetn asynchronous active low.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
`include "uart_modem_irq_map.vh"
module irq_mask_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and interrupt
  input wire logic clear_to_send_in_n,
  input wire logic irq
);
  // Word address and phase decode
  wire logic [11:0] wa = {paddr[11:2], 2'b00};
  wire logic setup = psel & ~penable;
  wire logic rd = setup & ~pwrite;
  wire logic unm = (wa < `OFS_MODEM_LINE_STATUS) || (wa > `OFS_IRQ_STATUS_CLEAR);
  wire logic clr_all = psel & penable & pready & pwrite & pstrb[0] & (wa == `OFS_IRQ_MASK_CLEAR)
    & (pwdata[7:0] == 8'hff);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (setup |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_err_when_unmapped: assert property (setup |=> pslverr == $past(unm)) else $error("bad slverr");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("slverr alone");
  a_status_reserved_zero: assert property (rd && wa == `OFS_MODEM_LINE_STATUS |=>
    prdata[31:5] == 0 && prdata[3:1] == 0) else $error("status reserved set");
  a_cts_level_inverted: assert property (rd && wa == `OFS_MODEM_LINE_STATUS && $past(presetn)
    |-> ##1 prdata[4] == !$past(clear_to_send_in_n, 2)) else $error("cts level wrong");
  a_write_only_zero: assert property (rd && (wa == `OFS_IRQ_MASK_SET ||
    wa == `OFS_IRQ_MASK_CLEAR) |=> prdata == 0) else $error("write-only read nonzero");
  a_view_upper_zero: assert property (rd && wa == `OFS_IRQ_MASK_VIEW |=>
    prdata[31:8] == 0) else $error("view upper set");
  a_mask_all_quiet: assert property (clr_all |=> ##1 !irq) else $error("irq while masked");
endmodule
bind uart_modem_status_irq_mask irq_mask_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clear_to_send_in_n(clear_to_send_in_n), .irq(irq));
`default_nettype wire

//--- verification/uart_modem_status_irq_mask_tb_top.sv
// Purpose: Self-checking bench for modem status and interrupt masking.
// Assumes: APB master with one request at a time, pclk 10 MHz.
// Notes:   Expected values come from the register map only.
`timescale 1ns/10ps
`default_nettype none
`include "uart_modem_irq_map.vh"
module uart_modem_status_irq_mask_tb_top;
  logic pclk, presetn, psel, penable, pwrite, ask, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [3:0] pstrb;
  logic [7:0] ev;
  wire [31:0] prdata;
  wire pready, pslverr, irq, cts_n;
  int error_cnt, checked;
  // 100 ns clock
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task report_and_stop;
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; a stuck slave ends the run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        error_cnt++;
        report_and_stop;
      end
      @(posedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    check($sformatf("reg %h", a), rdat, e);
  endtask
  task pulse(input logic [7:0] b);
    @(posedge pclk);
    ev <= b;
    @(posedge pclk);
    ev <= 0;
  endtask
  task t_reset;
    rd(`OFS_MODEM_LINE_STATUS, 0);
    rd(`OFS_IRQ_MASK_VIEW, 0);
    rd(`OFS_IRQ_RAW_FLAGS, 32'h2);
    rd(`OFS_IRQ_MASK_SET, 0);
    rd(`OFS_IRQ_MASK_CLEAR, 0);
    check("irq", irq, 0);
  endtask
  // Each source but modem change alone: masked, unmasked, then cleared
  task t_sources;
    int i;
    logic [7:0] b;
    apb(1, `OFS_IRQ_STATUS_CLEAR, 32'hff);
    for (i = 0; i < 8; i++)
    begin
      if (i == 3)
        continue;
      b = 8'h1 << i;
      pulse(b);
      rd(`OFS_IRQ_RAW_FLAGS, b);
      rd(`OFS_IRQ_STATUS_CLEAR, 0);
      apb(1, `OFS_IRQ_MASK_SET, b);
      repeat (2) @(posedge pclk);
      check("irq", irq, 1);
      rd(`OFS_IRQ_STATUS_CLEAR, b);
      apb(1, `OFS_IRQ_MASK_CLEAR, b);
      repeat (2) @(posedge pclk);
      check("irq", irq, 0);
      apb(1, `OFS_IRQ_STATUS_CLEAR, b);
      rd(`OFS_IRQ_RAW_FLAGS, 0);
    end
  endtask
  task t_mask_bits;
    apb(1, `OFS_IRQ_MASK_SET, 32'h05);
    apb(1, `OFS_IRQ_MASK_SET, 32'h80);
    rd(`OFS_IRQ_MASK_VIEW, 32'h85);
    apb(1, `OFS_IRQ_MASK_CLEAR, 32'h04);
    rd(`OFS_IRQ_MASK_VIEW, 32'h81);
    pstrb <= 0;
    apb(1, `OFS_IRQ_MASK_CLEAR, 32'hff);
    pstrb <= 4'h1;
    apb(1, `OFS_IRQ_MASK_SET, 32'hffffff00);
    rd(`OFS_IRQ_MASK_VIEW, 32'h81);
    apb(1, `OFS_IRQ_MASK_CLEAR, 32'hff);
    rd(`OFS_IRQ_MASK_VIEW, 0);
    rd(12'h100, 0);
    check("slverr", err, 1);
  endtask
  // Modem line change, flag, read-clear and modem interrupt
  task t_cts;
    apb(1, `OFS_IRQ_MASK_SET, 32'h08);
    ask <= 1;
    repeat (6) @(posedge pclk);
    check("irq", irq, 1);
    rd(`OFS_MODEM_LINE_STATUS, 32'h11);
    repeat (2) @(posedge pclk);
    check("irq", irq, 0);
    rd(`OFS_MODEM_LINE_STATUS, 32'h10);
    ask <= 0;
    repeat (6) @(posedge pclk);
    rd(`OFS_MODEM_LINE_STATUS, 32'h01);
    rd(`OFS_MODEM_LINE_STATUS, 0);
  endtask
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'h1;
    ev = 0;
    ask = 0;
    error_cnt = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_sources;
    t_mask_bits;
    t_cts;
    report_and_stop;
  end
  cts_modem modem (.pclk(pclk), .assert_req(ask), .clear_to_send_in_n(cts_n));
  uart_modem_status_irq_mask dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clear_to_send_in_n(cts_n),
    .rx_avail_event(ev[0]), .tx_empty_event(ev[1]), .line_status_event(ev[2]),
    .char_timeout_event(ev[4]), .busy_event(ev[5]), .autobaud_done_event(ev[6]),
    .autobaud_timeout_event(ev[7]), .irq(irq));
endmodule
`default_nettype wire
